// *** hdl/vefc_map.svh ***
/*
  Register offsets, field positions and timing figures of the voice,
  envelope and filter control block.
  Assumes inclusion by bare name from the top module.
*/
`ifndef VEFC_MAP_SVH
`define VEFC_MAP_SVH

// Register offsets (5-bit register index)
`define VEFC_VOICE_REGS      5'h07
`define VEFC_OFS_FREQ_LO     3'h0
`define VEFC_OFS_FREQ_HI     3'h1
`define VEFC_OFS_PW_LO       3'h2
`define VEFC_OFS_PW_HI       3'h3
`define VEFC_OFS_CTRL        3'h4
`define VEFC_OFS_RISE_FALL   3'h5
`define VEFC_OFS_HOLD_FADE   3'h6
`define VEFC_REG_CUTOFF_LO   5'h15
`define VEFC_REG_CUTOFF_HI   5'h16
`define VEFC_REG_PEAK_ROUTE  5'h17
`define VEFC_REG_TYPE_LEVEL  5'h18
`define VEFC_REG_PADDLE_X    5'h19
`define VEFC_REG_PADDLE_Y    5'h1A
`define VEFC_REG_V3_WAVE     5'h1B
`define VEFC_REG_V3_ENV      5'h1C
`define VEFC_LAST_VOICE_REG  5'h14

// Control register bits
`define VEFC_CTRL_GATE       0
`define VEFC_CTRL_SYNC       1
`define VEFC_CTRL_RING       2
`define VEFC_CTRL_TEST       3
`define VEFC_CTRL_TRI        4
`define VEFC_CTRL_SAW        5
`define VEFC_CTRL_PULSE      6
`define VEFC_CTRL_NOISE      7

// Mode/level register bits
`define VEFC_MODE_LP         4
`define VEFC_MODE_BP         5
`define VEFC_MODE_HP         6
`define VEFC_MODE_V3_OFF     7

// Envelope
`define VEFC_ENV_PEAK        8'hFF
`define VEFC_ENV_STEPS       255
`define VEFC_LEVEL_SCALE     8'h11
`define VEFC_PADDLE_PERIOD   10'h200
`define VEFC_RESET_HOLD      10

// Full-scale rise times in microseconds at the 1 MHz reference clock
`define VEFC_RISE_US_0       2000
`define VEFC_RISE_US_1       8000
`define VEFC_RISE_US_2       16000
`define VEFC_RISE_US_3       24000
`define VEFC_RISE_US_4       38000
`define VEFC_RISE_US_5       56000
`define VEFC_RISE_US_6       68000
`define VEFC_RISE_US_7       80000
`define VEFC_RISE_US_8       100000
`define VEFC_RISE_US_9       250000
`define VEFC_RISE_US_10      500000
`define VEFC_RISE_US_11      800000
`define VEFC_RISE_US_12      1000000
`define VEFC_RISE_US_13      3000000
`define VEFC_RISE_US_14      5000000
`define VEFC_RISE_US_15      8000000
// Fall times are three times the rise time of the same code
`define VEFC_FALL_FACTOR     3

`endif

// *** hdl/vefc_pkg.sv ***
/*
  Types shared by the voice, envelope and filter control block.
  Assumes vefc_map.svh on the include path.
*/
package vefc_pkg;

  typedef struct packed {
    logic [15:0] freq;
    logic [11:0] pw;
    logic [7:0]  ctrl;
    logic [7:0]  rise_fall;
    logic [7:0]  hold_fade;
  } vefc_voice_type;

  typedef struct packed {
    logic [10:0] cutoff;
    logic [3:0]  peaking_code;
    logic [3:0]  route;
    logic        lowpass_output_select;
    logic        bandpass_output_select;
    logic        highpass_output_select;
    logic        voice3_direct_off;
    logic [3:0]  master_level_code;
  } vefc_filter_type;

  typedef enum logic [1:0] {
    ENV_RISE,
    ENV_FALL_HOLD,
    ENV_FADE
  } vefc_env_state_type;

endpackage

// *** hdl/vefc_top.sv ***
/*
  Three-voice envelope, oscillator-readback and filter control core with
  its parallel register port.
  Assumes synchronous inputs on MCLK_IN, an external analog filter fed
  from the filter settings and mix outputs, and a host that keeps
  SRST_IN high for at least ten clocks.
*/
// Summary of operation
// - Upper attack/decay nibble picks one of sixteen rise rates.
// - Lower attack/decay nibble picks one of sixteen fall-to-hold rates.
// - Rise codes give 2 ms to 8 s full scale at reference clock.
// - Fall and fade codes give 6 ms to 24 s full scale.
// - All envelope timing counts master clocks, scaling with clock rate.
// - Upper hold/fade nibble gives sixteen linear hold levels, 8 is half.
// - Envelope stays at hold level while gate stays set.
// - Lower hold/fade nibble picks fade rate, same table as fall.
// - Clearing gate anytime starts fade from the present amplitude.
// - Setting gate during fade restarts rise from the present amplitude.
// - Voice two uses next seven registers, synced by oscillator one.
// - Voice three uses following seven registers, synced by oscillator two.
// - Cutoff is eleven bits: low register bits 2..0 plus high register.
// - Upper peaking/routing nibble gives sixteen resonance settings.
// - Low four bits route voice one, two, three, external through filter.
// - Mode bits four to six enable low, band, high pass independently.
// - Mode bit seven removes voice three from the direct path.
// - Lower mode nibble scales the direct mix output in sixteen steps; the filter feed is unscaled.
// - Paddle X register holds converted value refreshed every 512 clocks.
// - Paddle Y register behaves the same for the second input.
// - Voice three readback returns top eight oscillator bits.
// - Readback follows the chosen voice three waveform shape.
// - Control bit zero is gate: one starts rise, zero starts fade.
// - Reset held ten clocks clears all registers and silences output.
// - Transfer only with select low and bus clock high; RW picks direction.
`timescale 1ns/1ps
`include "vefc_map.svh"

module vefc_top
  import vefc_pkg::*;
#(
  parameter int ENV_TIME_SCALE = 1
)
(
  input  wire logic        MCLK_IN,
  input  wire logic        SRST_IN,
  input  wire logic        PHI2_IN,
  input  wire logic        CS_N_IN,
  input  wire logic        RW_IN,
  input  wire logic [4:0]  ADDR_IN,
  input  wire logic [7:0]  DATA_IN,
  output logic      [7:0]  DATA_OUT,
  output logic             DATA_OE_N_OUT,
  input  wire logic [7:0]  PADDLE_X_INPUT_IN,
  input  wire logic [7:0]  PADDLE_Y_INPUT_IN,
  output vefc_filter_type  FILTER_CFG_OUT,
  output logic      [23:0] ENV_LEVEL_OUT,
  output logic      [9:0]  FILTER_FEED_OUT,
  output logic      [13:0] DIRECT_MIX_OUT
);

  localparam int CNT_W = 18;

  vefc_voice_type          voice_ff [3];
  vefc_filter_type         filter_ff;
  vefc_env_state_type      env_state_ff [3];
  logic [7:0]              env_ff [3];
  logic [CNT_W-1:0]        presc_ff [3];
  logic                    gate_q_ff [3];
  logic [23:0]             acc_ff [3];
  logic [22:0]             lfsr_ff [3];
  logic                    noise_clk_q_ff [3];
  logic                    src_msb_q_ff [3];
  logic [7:0]              wave [3];
  logic [7:0]              amp [3];
  logic [8:0]              paddle_cnt_ff;
  logic [7:0]              paddle_x_ff;
  logic [7:0]              paddle_y_ff;
  logic [7:0]              rd_data_ff;
  logic [7:0]              nxt_rd_data;
  logic                    xfer;
  logic                    wr_strobe;
  logic                    rd_strobe;
  logic [9:0]              nxt_feed;
  logic [13:0]             nxt_direct;
  logic [9:0]              feed_ff;
  logic [13:0]             direct_ff;

  // Rise step period in master clocks for a rate code
  function automatic logic [CNT_W-1:0] rise_period(input logic [3:0] code);
    int us;
    case (code)
      4'h0:    us = `VEFC_RISE_US_0;
      4'h1:    us = `VEFC_RISE_US_1;
      4'h2:    us = `VEFC_RISE_US_2;
      4'h3:    us = `VEFC_RISE_US_3;
      4'h4:    us = `VEFC_RISE_US_4;
      4'h5:    us = `VEFC_RISE_US_5;
      4'h6:    us = `VEFC_RISE_US_6;
      4'h7:    us = `VEFC_RISE_US_7;
      4'h8:    us = `VEFC_RISE_US_8;
      4'h9:    us = `VEFC_RISE_US_9;
      4'hA:    us = `VEFC_RISE_US_10;
      4'hB:    us = `VEFC_RISE_US_11;
      4'hC:    us = `VEFC_RISE_US_12;
      4'hD:    us = `VEFC_RISE_US_13;
      4'hE:    us = `VEFC_RISE_US_14;
      default: us = `VEFC_RISE_US_15;
    endcase
    // One master clock is one microsecond at the reference rate
    us = us / (`VEFC_ENV_STEPS * ENV_TIME_SCALE);
    if (us < 1)
    begin
      us = 1;
    end
    return CNT_W'(us);
  endfunction

  function automatic logic [CNT_W-1:0] fall_period(input logic [3:0] code);
    return CNT_W'(`VEFC_FALL_FACTOR * int'(rise_period(code)));
  endfunction

  // Voice index of a voice register address, 3 when not a voice register
  function automatic logic [1:0] voice_of(input logic [4:0] addr);
    if (addr > `VEFC_LAST_VOICE_REG)
    begin
      return 2'h3;
    end
    return 2'(addr / `VEFC_VOICE_REGS);
  endfunction

  function automatic logic [2:0] offset_of(input logic [4:0] addr);
    return 3'(addr % `VEFC_VOICE_REGS);
  endfunction

  // Bus clock high acts as an active-high select
  assign xfer      = !CS_N_IN && PHI2_IN;
  assign wr_strobe = xfer && !RW_IN;
  assign rd_strobe = xfer && RW_IN;

  // Voice register images; writes repeat harmlessly while strobe is held
  always_ff @(posedge MCLK_IN)
  begin
    for (int v = 0; v < 3; v++)
    begin
      if (SRST_IN)
      begin
        voice_ff[v] <= '0;
      end
      else if (wr_strobe && voice_of(ADDR_IN) == 2'(v))
      begin
        case (offset_of(ADDR_IN))
          `VEFC_OFS_FREQ_LO:   voice_ff[v].freq[7:0]  <= DATA_IN;
          `VEFC_OFS_FREQ_HI:   voice_ff[v].freq[15:8] <= DATA_IN;
          `VEFC_OFS_PW_LO:     voice_ff[v].pw[7:0]    <= DATA_IN;
          `VEFC_OFS_PW_HI:     voice_ff[v].pw[11:8]   <= DATA_IN[3:0];
          `VEFC_OFS_CTRL:      voice_ff[v].ctrl       <= DATA_IN;
          `VEFC_OFS_RISE_FALL: voice_ff[v].rise_fall  <= DATA_IN;
          default:             voice_ff[v].hold_fade  <= DATA_IN;
        endcase
      end
    end
  end

  // Filter and output control image
  always_ff @(posedge MCLK_IN)
  begin
    if (SRST_IN)
    begin
      filter_ff <= '0;
    end
    else if (wr_strobe)
    begin
      case (ADDR_IN)
        `VEFC_REG_CUTOFF_LO:
          filter_ff.cutoff[2:0] <= DATA_IN[2:0];
        `VEFC_REG_CUTOFF_HI:
          filter_ff.cutoff[10:3] <= DATA_IN;
        `VEFC_REG_PEAK_ROUTE:
        begin
          filter_ff.peaking_code <= DATA_IN[7:4];
          filter_ff.route        <= DATA_IN[3:0];
        end
        `VEFC_REG_TYPE_LEVEL:
        begin
          filter_ff.lowpass_output_select  <= DATA_IN[`VEFC_MODE_LP];
          filter_ff.bandpass_output_select <= DATA_IN[`VEFC_MODE_BP];
          filter_ff.highpass_output_select <= DATA_IN[`VEFC_MODE_HP];
          filter_ff.voice3_direct_off      <= DATA_IN[`VEFC_MODE_V3_OFF];
          filter_ff.master_level_code      <= DATA_IN[3:0];
        end
        default:
        begin
          // Read-only and unused locations ignore writes
        end
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : gen_voice
      // Sync and ring source is the previous oscillator, voice one uses three
      localparam int SRC = (g + 2) % 3;
      logic [3:0] rise_rate_code;
      logic [3:0] fall_rate_code;
      logic [3:0] hold_level_code;
      logic [3:0] fade_rate_code;
      logic [7:0] hold_level;
      logic       gate;
      logic [CNT_W-1:0] period;
      logic       step;
      logic       src_msb;
      logic       tri_msb;
      logic [7:0] tri_w;
      logic [7:0] saw_w;
      logic [7:0] pulse_w;
      logic [7:0] noise_w;
      logic [7:0] sel;
      logic [15:0] prod;

      assign rise_rate_code  = voice_ff[g].rise_fall[7:4];
      assign fall_rate_code  = voice_ff[g].rise_fall[3:0];
      assign hold_level_code = voice_ff[g].hold_fade[7:4];
      assign fade_rate_code  = voice_ff[g].hold_fade[3:0];
      assign hold_level = 8'(hold_level_code * `VEFC_LEVEL_SCALE);
      assign gate = voice_ff[g].ctrl[`VEFC_CTRL_GATE];

      always_comb
      begin
        case (env_state_ff[g])
          ENV_RISE:      period = rise_period(rise_rate_code);
          ENV_FALL_HOLD: period = fall_period(fall_rate_code);
          default:       period = fall_period(fade_rate_code);
        endcase
      end

      // Prescaler counts master clocks, so rates scale with the clock
      assign step = presc_ff[g] >= period - CNT_W'(1);

      always_ff @(posedge MCLK_IN)
      begin
        if (SRST_IN || step || (gate != gate_q_ff[g]))
        begin
          presc_ff[g] <= '0;
        end
        else
        begin
          presc_ff[g] <= presc_ff[g] + CNT_W'(1);
        end
      end

      always_ff @(posedge MCLK_IN)
      begin
        if (SRST_IN)
        begin
          gate_q_ff[g] <= 1'b0;
        end
        else
        begin
          gate_q_ff[g] <= gate;
        end
      end

      // Phase changes keep the amplitude, so no jump on re-gating
      always_ff @(posedge MCLK_IN)
      begin
        if (SRST_IN)
        begin
          env_state_ff[g] <= ENV_FADE;
          env_ff[g]       <= 8'h00;
        end
        else if (gate && !gate_q_ff[g])
        begin
          env_state_ff[g] <= ENV_RISE;
        end
        else if (!gate && gate_q_ff[g])
        begin
          env_state_ff[g] <= ENV_FADE;
        end
        else if (step)
        begin
          case (env_state_ff[g])
            ENV_RISE:
            begin
              if (env_ff[g] == `VEFC_ENV_PEAK)
              begin
                env_state_ff[g] <= ENV_FALL_HOLD;
              end
              else
              begin
                env_ff[g] <= env_ff[g] + 8'h01;
              end
            end
            ENV_FALL_HOLD:
            begin
              if (env_ff[g] > hold_level)
              begin
                env_ff[g] <= env_ff[g] - 8'h01;
              end
              // Otherwise rests at hold level until the gate drops
            end
            ENV_FADE:
            begin
              if (env_ff[g] != 8'h00)
              begin
                env_ff[g] <= env_ff[g] - 8'h01;
              end
            end
            default:
            begin
              env_state_ff[g] <= ENV_FADE;
            end
          endcase
        end
      end

      // Phase accumulator with hard sync and test hold
      assign src_msb = acc_ff[SRC][23];
      always_ff @(posedge MCLK_IN)
      begin
        if (SRST_IN)
        begin
          acc_ff[g]       <= '0;
          src_msb_q_ff[g] <= 1'b0;
        end
        else
        begin
          src_msb_q_ff[g] <= src_msb;
          if (voice_ff[g].ctrl[`VEFC_CTRL_TEST] ||
              (voice_ff[g].ctrl[`VEFC_CTRL_SYNC] && src_msb && !src_msb_q_ff[g]))
          begin
            acc_ff[g] <= '0;
          end
          else
          begin
            acc_ff[g] <= acc_ff[g] + {8'h00, voice_ff[g].freq};
          end
        end
      end

      // Noise shift register clocked by accumulator bit 19
      always_ff @(posedge MCLK_IN)
      begin
        if (SRST_IN || voice_ff[g].ctrl[`VEFC_CTRL_TEST])
        begin
          lfsr_ff[g]        <= 23'h7FFFFF;
          noise_clk_q_ff[g] <= 1'b0;
        end
        else
        begin
          noise_clk_q_ff[g] <= acc_ff[g][19];
          if (acc_ff[g][19] && !noise_clk_q_ff[g])
          begin
            lfsr_ff[g] <= {lfsr_ff[g][21:0], lfsr_ff[g][22] ^ lfsr_ff[g][17]};
          end
        end
      end

      // Waveforms; several selected combine by AND
      assign tri_msb = acc_ff[g][23] ^ (voice_ff[g].ctrl[`VEFC_CTRL_RING] && src_msb);
      assign tri_w   = tri_msb ? ~acc_ff[g][22:15] : acc_ff[g][22:15];
      assign saw_w   = acc_ff[g][23:16];
      assign pulse_w = (acc_ff[g][23:12] >= voice_ff[g].pw) ? 8'hFF : 8'h00;
      assign noise_w = {lfsr_ff[g][22], lfsr_ff[g][20], lfsr_ff[g][16],
                        lfsr_ff[g][13], lfsr_ff[g][11], lfsr_ff[g][7],
                        lfsr_ff[g][4], lfsr_ff[g][2]};

      always_comb
      begin
        sel = 8'hFF;
        if (voice_ff[g].ctrl[`VEFC_CTRL_TRI])
        begin
          sel = sel & tri_w;
        end
        if (voice_ff[g].ctrl[`VEFC_CTRL_SAW])
        begin
          sel = sel & saw_w;
        end
        if (voice_ff[g].ctrl[`VEFC_CTRL_PULSE])
        begin
          sel = sel & pulse_w;
        end
        if (voice_ff[g].ctrl[`VEFC_CTRL_NOISE])
        begin
          sel = sel & noise_w;
        end
        if (voice_ff[g].ctrl[7:4] == 4'h0)
        begin
          sel = 8'h00;
        end
      end
      assign wave[g] = sel;

      assign prod   = wave[g] * env_ff[g];
      assign amp[g] = prod[15:8];
      assign ENV_LEVEL_OUT[g*8 +: 8] = env_ff[g];
    end
  endgenerate

  // Paddle values refreshed on a fixed 512-clock frame
  always_ff @(posedge MCLK_IN)
  begin
    if (SRST_IN)
    begin
      paddle_cnt_ff <= '0;
      paddle_x_ff   <= 8'h00;
      paddle_y_ff   <= 8'h00;
    end
    else
    begin
      paddle_cnt_ff <= paddle_cnt_ff + 9'h001;
      if (paddle_cnt_ff == 9'(`VEFC_PADDLE_PERIOD - 10'h001))
      begin
        paddle_x_ff <= PADDLE_X_INPUT_IN;
        paddle_y_ff <= PADDLE_Y_INPUT_IN;
      end
    end
  end

  always_comb
  begin
    case (ADDR_IN)
      `VEFC_REG_PADDLE_X: nxt_rd_data = paddle_x_ff;
      `VEFC_REG_PADDLE_Y: nxt_rd_data = paddle_y_ff;
      `VEFC_REG_V3_WAVE:  nxt_rd_data = wave[2];
      `VEFC_REG_V3_ENV:   nxt_rd_data = env_ff[2];
      default:            nxt_rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (SRST_IN)
    begin
      rd_data_ff <= 8'h00;
    end
    else
    begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign DATA_OUT      = rd_data_ff;
  assign DATA_OE_N_OUT = !(rd_strobe && !SRST_IN);
  assign FILTER_CFG_OUT = filter_ff;

  // Digital mixes: routed voices feed the filter, the rest go direct unless mode bit seven drops voice three
  always_comb
  begin
    logic [9:0] direct;
    direct   = 10'h000;
    nxt_feed = 10'h000;
    for (int v = 0; v < 3; v++)
    begin
      if (filter_ff.route[v])
      begin
        nxt_feed = nxt_feed + {2'b00, amp[v]};
      end
      else if (!(v == 2 && filter_ff.voice3_direct_off))
      begin
        direct = direct + {2'b00, amp[v]};
      end
    end
    nxt_direct = direct * filter_ff.master_level_code;
  end

  // Mixes leave through flops, so setting changes show one clock later
  always_ff @(posedge MCLK_IN)
  begin
    if (SRST_IN)
    begin
      feed_ff   <= 10'h000;
      direct_ff <= 14'h0000;
    end
    else
    begin
      feed_ff   <= nxt_feed;
      direct_ff <= nxt_direct;
    end
  end

  assign FILTER_FEED_OUT = feed_ff;
  assign DIRECT_MIX_OUT  = direct_ff;

endmodule

// *** testbench/vefc_top_monitor.sv ***
/*
  Port assertions for vefc_top, bound below the checker.
  Assumes the single MCLK_IN domain and a synchronous SRST_IN.
*/
`timescale 1ns/1ps
module vefc_top_monitor
  import vefc_pkg::*;
(
  input  wire logic            MCLK_IN,
  input  wire logic            SRST_IN,
  input  wire logic            PHI2_IN,
  input  wire logic            CS_N_IN,
  input  wire logic            RW_IN,
  input  wire logic [4:0]      ADDR_IN,
  input  wire logic [7:0]      DATA_IN,
  input  wire logic [7:0]      DATA_OUT,
  input  wire logic            DATA_OE_N_OUT,
  input  wire vefc_filter_type FILTER_CFG_OUT,
  input  wire logic [23:0]     ENV_LEVEL_OUT,
  input  wire logic [13:0]     DIRECT_MIX_OUT
);
  logic rd;
  logic wr;
  assign rd = !CS_N_IN && PHI2_IN && RW_IN;
  assign wr = !CS_N_IN && PHI2_IN && !RW_IN;

  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (SRST_IN);

  a_oe_on_read: assert property (DATA_OE_N_OUT == !rd)
    else $error("data enable does not follow read strobe");
  a_idle_no_write: assert property (CS_N_IN |=> $stable(FILTER_CFG_OUT))
    else $error("filter settings changed while deselected");
  a_cutoff_low_bits: assert property (wr && ADDR_IN == 5'h15 |=>
    FILTER_CFG_OUT.cutoff[2:0] == 3'($past(DATA_IN)))
    else $error("cutoff low bits wrong");
  a_cutoff_high_bits: assert property (wr && ADDR_IN == 5'h16 |=>
    FILTER_CFG_OUT.cutoff[10:3] == $past(DATA_IN))
    else $error("cutoff high bits wrong");
  a_peak_route_write: assert property (wr && ADDR_IN == 5'h17 |=>
    {FILTER_CFG_OUT.peaking_code, FILTER_CFG_OUT.route} == $past(DATA_IN))
    else $error("peaking or routing wrong");
  a_mode_level_write: assert property (wr && ADDR_IN == 5'h18 |=>
    {FILTER_CFG_OUT.voice3_direct_off, FILTER_CFG_OUT.highpass_output_select,
     FILTER_CFG_OUT.bandpass_output_select, FILTER_CFG_OUT.lowpass_output_select,
     FILTER_CFG_OUT.master_level_code} == $past(DATA_IN))
    else $error("mode or level wrong");
  a_mute_at_zero: assert property (FILTER_CFG_OUT.master_level_code == 4'h0 |=>
    DIRECT_MIX_OUT == 14'h0000)
    else $error("direct mix not silent at level zero");
  a_env_single_step: assert property (!$stable(ENV_LEVEL_OUT[7:0]) |->
    (8'(ENV_LEVEL_OUT) - 8'($past(ENV_LEVEL_OUT))) inside {8'h01, 8'hFF})
    else $error("envelope jumped by more than one step");
  a_wo_read_zero: assert property (rd && ADDR_IN <= 5'h18 ##1
    rd && $stable(ADDR_IN) |-> DATA_OUT == 8'h00)
    else $error("write-only register read back nonzero");

  c_mode_write: cover property (wr && ADDR_IN == 5'h18);
  c_env_peak: cover property (ENV_LEVEL_OUT[7:0] == 8'hFF);
  c_paddle_read: cover property (rd && ADDR_IN == 5'h19);
endmodule

bind vefc_top vefc_top_monitor vefc_top_monitor_inst (
  .MCLK_IN(MCLK_IN), .SRST_IN(SRST_IN), .PHI2_IN(PHI2_IN), .CS_N_IN(CS_N_IN),
  .RW_IN(RW_IN), .ADDR_IN(ADDR_IN), .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT),
  .DATA_OE_N_OUT(DATA_OE_N_OUT), .FILTER_CFG_OUT(FILTER_CFG_OUT),
  .ENV_LEVEL_OUT(ENV_LEVEL_OUT), .DIRECT_MIX_OUT(DIRECT_MIX_OUT)
);

// *** testbench/vefc_host_model.sv ***
/*
  Host processor model on the parallel register port.
  Assumes the caller runs one transfer at a time.
*/
`timescale 1ns/1ps
module vefc_host_model
(
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  output logic            cs_n_out,
  output logic            phi2_out,
  output logic            rw_out,
  output logic [4:0]      addr_out,
  output logic [7:0]      data_out
);
  initial
  begin
    cs_n_out = 1'b1;
    phi2_out = 1'b0;
    rw_out   = 1'b1;
    addr_out = 5'h00;
    data_out = 8'h00;
  end

  // Released data lines show the inverse, never a stale copy
  task automatic release_bus();
    cs_n_out = 1'b1;
    phi2_out = 1'b0;
    rw_out   = 1'b1;
    data_out = ~data_out;
  endtask

  task automatic write_reg(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk_in);
    cs_n_out = 1'b0;
    phi2_out = 1'b1;
    rw_out   = 1'b0;
    addr_out = a;
    data_out = d;
    @(posedge clk_in);
    @(negedge clk_in);
    release_bus();
  endtask

  task automatic read_reg(input logic [4:0] a, output logic [7:0] d);
    @(negedge clk_in);
    cs_n_out = 1'b0;
    phi2_out = 1'b1;
    rw_out   = 1'b1;
    addr_out = a;
    @(posedge clk_in);
    @(posedge clk_in);
    d = rdata_in;
    @(negedge clk_in);
    release_bus();
  endtask
endmodule

// *** testbench/vefc_top_tb.sv ***
/*
  Self-checking bench for vefc_top against an integer register model.
  Assumes vefc_host_model and the bound port checker.
*/
`timescale 1ns/1ps
module vefc_top_tb;
  import vefc_pkg::*;
  localparam int SCALE  = 64;
  localparam int RISE_P = 38000 / (255 * SCALE);

  logic            mclk;
  logic            srst;
  logic            cs_n;
  logic            phi2;
  logic            rw;
  logic [4:0]      addr;
  logic [7:0]      wdata;
  logic [7:0]      rdata;
  logic            oe_n;
  logic [7:0]      pad_x;
  logic [7:0]      pad_y;
  vefc_filter_type cfg;
  logic [23:0]     env;
  logic [13:0]     mix;
  logic [9:0]      feed;
  logic [7:0]      lvl;
  int              num_errors;
  int              num_checks;
  int              seed;
  int              model_q[32];
  int              n;
  int              h;

  vefc_top #(.ENV_TIME_SCALE(SCALE)) vefc_top_inst (
    .MCLK_IN(mclk), .SRST_IN(srst), .PHI2_IN(phi2), .CS_N_IN(cs_n), .RW_IN(rw),
    .ADDR_IN(addr), .DATA_IN(wdata), .DATA_OUT(rdata), .DATA_OE_N_OUT(oe_n),
    .PADDLE_X_INPUT_IN(pad_x), .PADDLE_Y_INPUT_IN(pad_y), .FILTER_CFG_OUT(cfg),
    .ENV_LEVEL_OUT(env), .FILTER_FEED_OUT(feed), .DIRECT_MIX_OUT(mix)
  );

  vefc_host_model vefc_host_model_inst (
    .clk_in(mclk), .rdata_in(rdata), .cs_n_out(cs_n), .phi2_out(phi2),
    .rw_out(rw), .addr_out(addr), .data_out(wdata)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic put(input logic [4:0] a, input logic [7:0] d);
    vefc_host_model_inst.write_reg(a, d);
    // Paddle and readback places ignore writes
    if (a < 5'h19)
      model_q[a] = d;
  endtask

  task automatic get(input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] d;
    vefc_host_model_inst.read_reg(a, d);
    check(d, exp);
  endtask

  function automatic vefc_filter_type exp_cfg();
    return {model_q[22][7:0], model_q[21][2:0], model_q[23][7:0], model_q[24][4],
            model_q[24][5], model_q[24][6], model_q[24][7], model_q[24][3:0]};
  endfunction

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  initial
  begin
    #(25 * 40000);
    num_errors++;
    conclude();
  end

  initial
  begin
    seed = 32'h1138;
    num_errors = 0;
    num_checks = 0;
    srst = 1'b1;
    pad_x = 8'h00;
    pad_y = 8'h00;
    for (int i = 0; i < 32; i++)
      model_q[i] = 0;
    repeat (10) @(negedge mclk);
    srst = 1'b0;
    check(cfg, 0);
    check(env, 0);
    check(oe_n, 1'b1);
    for (int i = 0; i < 8; i++)
    begin
      for (int a = 21; a < 25; a++)
        put(5'(a), 8'($random(seed)));
      check(cfg, exp_cfg());
    end
    pad_x = 8'($random(seed));
    pad_y = 8'($random(seed));
    put(5'h19, 8'($random(seed)));
    get(5'h05, 8'h00);
    get(5'h1B, 8'h00);
    // Test bit holds oscillator three at zero: pulse is high, saw is low
    put(5'h12, 8'h48);
    get(5'h1B, 8'hFF);
    put(5'h12, 8'h68);
    get(5'h1B, 8'h00);
    repeat (520) @(negedge mclk);
    get(5'h19, pad_x);
    get(5'h1A, pad_y);
    // Fast rise and fall so each voice settles well inside the wait
    for (int v = 0; v < 3; v++)
    begin
      h = 1 + ($unsigned($random(seed)) % 15);
      put(5'(7 * v + 5), 8'h00);
      put(5'(7 * v + 6), 8'(h << 4));
      put(5'(7 * v + 4), 8'h01);
      repeat (1500) @(negedge mclk);
      check(env[8 * v +: 8], h * 17);
      if (v == 2)
        get(5'h1C, 8'(h * 17));
      put(5'(7 * v + 4), 8'h00);
      repeat (1500) @(negedge mclk);
      check(env[8 * v +: 8], 0);
    end
    put(5'h05, 8'h40);
    put(5'h06, 8'hF0);
    put(5'h04, 8'h01);
    n = 0;
    while (env[7:0] !== 8'hFF && n < 2000)
    begin
      @(negedge mclk);
      n++;
    end
    check(n >= 255 * RISE_P - 4 && n <= 255 * RISE_P + 4, 1'b1);
    repeat (100) @(negedge mclk);
    check(env[7:0], 8'hFF);
    put(5'h04, 8'h00);
    repeat (1000) @(negedge mclk);
    put(5'h04, 8'h01);
    repeat (100) @(negedge mclk);
    lvl = env[7:0];
    put(5'h04, 8'h00);
    check(env[7:0] + 8'h01 >= lvl && env[7:0] <= lvl + 8'h02, 1'b1);
    repeat (20) @(negedge mclk);
    lvl = env[7:0];
    put(5'h04, 8'h01);
    check(env[7:0] + 8'h02 >= lvl && env[7:0] <= lvl + 8'h02, 1'b1);
    repeat (20) @(negedge mclk);
    check(env[7:0] > lvl, 1'b1);
    // Voice one at peak with a steady pulse, then routed and direct mixes
    put(5'h04, 8'h41);
    put(5'h17, 8'h01);
    put(5'h18, 8'h0F);
    repeat (600) @(negedge mclk);
    lvl = 8'((255 * 255) >> 8);
    check(feed, lvl);
    check(mix, 0);
    put(5'h17, 8'h00);
    repeat (2) @(negedge mclk);
    check(feed, 0);
    check(mix, lvl * 15);
    put(5'h18, 8'h05);
    repeat (2) @(negedge mclk);
    check(mix, lvl * 5);
    put(5'h18, 8'h00);
    repeat (2) @(negedge mclk);
    check(mix, 0);
    put(5'h18, 8'h0F);
    // Reset in mid-run while the voice is sounding
    srst = 1'b1;
    repeat (10) @(negedge mclk);
    srst = 1'b0;
    check(cfg, 0);
    check(env, 0);
    check({feed, mix}, 0);
    put(5'h18, 8'h0F);
    check(cfg, 32'h0000000F);
    conclude();
  end
endmodule
